// File: sg_link_checker.sv
`default_nettype none

module sg_link_checker
  import sg_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic desc_valid,
  input wire logic desc_ready,
  input wire logic [31:0] desc_ctrl,
  input wire logic wb_valid,
  input wire logic [31:0] wb_status,
  input wire logic rd_req_valid,
  input wire logic [LEN_W-1:0] rd_req_len,
  input wire logic rd_data_valid,
  input wire logic rd_data_ready,
  input wire logic [1:0] rd_resp,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic cs_valid,
  input wire logic cs_ready,
  input wire logic cs_last
);
  ////////////////////////////////////////////////////////////
  // Handshake decodes
  wire taken = desc_valid && desc_ready;
  wire beat = rd_data_valid && rd_data_ready;
  logic [LEN_W-1:0] cur_len;
  logic cur_eof;
  logic slv_seen;
  logic dec_seen;
  logic [2:0] cs_cnt;

  // Descriptor in flight; error marks restart with each fetch
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || taken) begin
      cur_len <= desc_ctrl[LEN_W-1:0];
      cur_eof <= desc_ctrl[CTRL_EOF_BIT];
      slv_seen <= 1'b0;
      dec_seen <= 1'b0;
    end else if (beat) begin
      slv_seen <= slv_seen || (rd_resp == RESP_SLVERR);
      dec_seen <= dec_seen || (rd_resp == RESP_DECERR);
    end
  end

  // Control stream word position, so a short or long burst shows up
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_cnt <= 3'h0;
    end else if (cs_valid && cs_ready) begin
      cs_cnt <= cs_last ? 3'h0 : cs_cnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_req_length: assert property (rd_req_valid |-> rd_req_len == cur_len)
    else $error("read length differs from descriptor length");
  a_no_zero_read: assert property (rd_req_valid |-> rd_req_len != '0)
    else $error("zero byte read issued");
  a_zero_len_status: assert property (taken && desc_ctrl[LEN_W-1:0] == '0
    |-> ##[1:16] (wb_valid && wb_status == 32'h1000_0000))
    else $error("zero length did not report internal error");
  a_okay_bytes: assert property (wb_valid && wb_status[ST_CMPLT_BIT] |-> wb_status[LEN_W-1:0] == cur_len)
    else $error("byte count differs from buffer length");
  a_status_clean: assert property (wb_valid
    |-> wb_status[27:23] == 5'h0 && !(wb_status[ST_CMPLT_BIT] && |wb_status[30:28]))
    else $error("status word inconsistent");
  a_slave_flag: assert property (wb_valid |-> wb_status[ST_SLV_BIT] == slv_seen)
    else $error("slave error bit wrong");
  a_decode_flag: assert property (wb_valid |-> wb_status[ST_DEC_BIT] == dec_seen)
    else $error("decode error bit wrong");
  // A zero-length start descriptor is refused before its user words go out
  a_cs_after_sof: assert property (taken && desc_ctrl[CTRL_SOF_BIT] && desc_ctrl[LEN_W-1:0] != '0
    |-> ##[1:4] cs_valid)
    else $error("control stream missing after start descriptor");
  a_cs_five_words: assert property (cs_valid && cs_ready && cs_last |-> cs_cnt == 3'h4)
    else $error("control stream burst length wrong");
  a_tx_last_eof: assert property (tx_valid && tx_last |-> cur_eof)
    else $error("frame ended on a non-final buffer");
  a_wb_single: assert property (wb_valid |=> !wb_valid)
    else $error("status written more than once");

  // Main scenarios reached
  c_zero_len: cover property (taken && desc_ctrl[LEN_W-1:0] == '0);
  c_slave_err: cover property (wb_valid && wb_status[ST_SLV_BIT]);
  c_multi_desc: cover property (taken && !desc_ctrl[CTRL_EOF_BIT]);

endmodule : sg_link_checker

`default_nettype wire

// File: sg_link_if.sv
`default_nettype none

interface sg_link_if (
  input wire logic clk_i,
  input wire logic sys_rst_i
);
  import sg_pkg::*;

  // Descriptor fetch
  logic desc_valid;
  logic desc_ready;
  logic [31:0] desc_ctrl;
  logic [31:0] desc_stat;
  logic [APP_W-1:0] desc_app;
  // Status write-back
  logic wb_valid;
  logic wb_ready;
  logic [31:0] wb_status;
  // Buffer read request and data
  logic rd_req_valid;
  logic rd_req_ready;
  logic [LEN_W-1:0] rd_req_len;
  logic rd_data_valid;
  logic rd_data_ready;
  logic [DATA_W-1:0] rd_data;
  logic [1:0] rd_resp;
  logic rd_last;
  // Transmit stream
  logic tx_valid;
  logic tx_ready;
  logic [DATA_W-1:0] tx_data;
  logic [KEEP_W-1:0] tx_keep;
  logic tx_last;
  // Control stream
  logic cs_valid;
  logic cs_ready;
  logic [DATA_W-1:0] cs_data;
  logic cs_last;

  modport engine (
    input clk_i, sys_rst_i,
    input desc_valid, desc_ctrl, desc_stat, desc_app, output desc_ready,
    output wb_valid, wb_status, input wb_ready,
    output rd_req_valid, rd_req_len, input rd_req_ready,
    input rd_data_valid, rd_data, rd_resp, rd_last, output rd_data_ready,
    output tx_valid, tx_data, tx_keep, tx_last, input tx_ready,
    output cs_valid, cs_data, cs_last, input cs_ready
  );

  modport system (
    input clk_i, sys_rst_i,
    output desc_valid, desc_ctrl, desc_stat, desc_app, input desc_ready,
    input wb_valid, wb_status, output wb_ready,
    input rd_req_valid, rd_req_len, output rd_req_ready,
    output rd_data_valid, rd_data, rd_resp, rd_last, input rd_data_ready,
    input tx_valid, tx_data, tx_keep, tx_last, output tx_ready,
    input cs_valid, cs_data, cs_last, output cs_ready
  );

endinterface : sg_link_if

`default_nettype wire

// File: sg_pkg.sv
// Summary of operation
// - Buffer length from control bits 22..0
// - Control bit 26 marks packet's last buffer
// - Control bit 27 marks packet's first buffer
// - Each packet has one start, one end
// - Start descriptor user words go on control stream
// - Software writes reserved control bits as zero
// - Status bits 22..0 hold bytes moved
// - Normal completion: byte count equals buffer length
// - Zero length sets internal error bit 28
// - Errors clear run, halt gracefully, then halted
// - Slave error response sets status bit 29
// - Decode error response sets status bit 30
// - Completed bit 31 set when transfer finishes
// - Already completed descriptor: stale, error, halt
// - Software reuses only completed descriptors
// - Descriptors sit on 16-word boundaries
`default_nettype none

package sg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int LEN_W = 23;
  localparam int DATA_W = 32;
  localparam int KEEP_W = 4;
  localparam int APP_N = 5;
  localparam int APP_W = APP_N * DATA_W;
  localparam bit CS_STRM_EN = 1'b1;
  localparam logic [31:0] DESC_ALIGN = 32'h0000_0040;

  ////////////////////////////////////////////////////////////////////////////
  // Control word fields
  localparam int CTRL_LEN_MSB = 22;
  localparam int CTRL_EOF_BIT = 26;
  localparam int CTRL_SOF_BIT = 27;

  // Status word fields
  localparam int ST_INT_BIT = 28;
  localparam int ST_SLV_BIT = 29;
  localparam int ST_DEC_BIT = 30;
  localparam int ST_CMPLT_BIT = 31;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;

  // Read response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Engine states
  typedef enum logic [2:0] {
    S_HALT = 3'b000,
    S_FETCH = 3'b001,
    S_CHECK = 3'b010,
    S_CTRL = 3'b011,
    S_REQ = 3'b100,
    S_DATA = 3'b101,
    S_DRAIN = 3'b110,
    S_WB = 3'b111
  } eng_state_t;

  // Bytes carried by the next beat given the bytes still owed
  function automatic logic [2:0] beat_bytes(input logic [LEN_W-1:0] rem);
    beat_bytes = (rem >= LEN_W'(KEEP_W)) ? 3'(KEEP_W) : rem[2:0];
  endfunction : beat_bytes

  // Byte enables for a beat of n bytes, low lanes first
  function automatic logic [KEEP_W-1:0] keep_of(input logic [2:0] n);
    keep_of = 4'(({KEEP_W{1'b1}} << n) ^ {KEEP_W{1'b1}});
    if (n >= 3'(KEEP_W)) begin
      keep_of = {KEEP_W{1'b1}};
    end
  endfunction : keep_of

endpackage : sg_pkg

`default_nettype wire

// File: sg_sys_end.sv
`default_nettype none

module sg_sys_end
  import sg_pkg::*;
(
  sg_link_if.system link,
  input wire logic push_i,
  input wire logic [LEN_W-1:0] len_i,
  input wire logic eof_i,
  input wire logic [APP_W-1:0] app_i,
  input wire logic [1:0] resp_sel_i,
  input wire logic tx_ready_i,
  output logic busy_o,
  output logic status_valid_o,
  output logic [31:0] status_o,
  output logic tx_word_valid_o,
  output logic [DATA_W-1:0] tx_word_o,
  output logic [KEEP_W-1:0] tx_keep_o,
  output logic tx_last_o,
  output logic cs_word_valid_o,
  output logic [DATA_W-1:0] cs_word_o
);

  logic in_packet;
  logic busy;
  logic desc_valid;
  logic [31:0] desc_ctrl;
  logic [APP_W-1:0] desc_app;
  logic [LEN_W-1:0] beats_left;
  logic [1:0] resp;
  logic data_valid;
  logic [DATA_W-1:0] data;
  logic tx_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor build: start flag forced at a packet's opening, reserved bits zero
  wire logic next_sof = !in_packet;
  wire logic [31:0] next_ctrl = {4'h0, next_sof, eof_i, 3'h0, len_i};
  wire logic [LEN_W-1:0] req_beats = (link.rd_req_len + LEN_W'(KEEP_W - 1)) >> 2;
  wire logic beat_hit = data_valid && link.rd_data_ready;
  wire logic last_beat = beats_left == LEN_W'(1);

  assign link.desc_valid = desc_valid;
  assign link.desc_ctrl = desc_ctrl;
  assign link.desc_stat = STATUS_RST;
  assign link.desc_app = desc_app;
  assign link.wb_ready = 1'b1;
  assign link.rd_req_ready = (beats_left == '0) && !data_valid;
  assign link.rd_data_valid = data_valid;
  assign link.rd_data = data;
  assign link.rd_resp = resp;
  assign link.rd_last = data_valid && last_beat;
  assign link.tx_ready = tx_ready;
  assign link.cs_ready = 1'b1;
  assign busy_o = busy;

  ////////////////////////////////////////////////////////////////////////////
  // Software side: one descriptor in flight, reused only after write-back
  always_ff @(posedge link.clk_i) begin
    if (link.sys_rst_i) begin
      in_packet <= 1'b0;
      busy <= 1'b0;
      desc_valid <= 1'b0;
      desc_ctrl <= 32'h0000_0000;
      desc_app <= '0;
      status_valid_o <= 1'b0;
      status_o <= STATUS_RST;
    end else begin
      status_valid_o <= link.wb_valid;
      if (link.wb_valid) begin
        status_o <= link.wb_status;
        busy <= 1'b0;
      end
      if (desc_valid && link.desc_ready) begin
        desc_valid <= 1'b0;
      end
      if (push_i && !busy) begin
        busy <= 1'b1;
        desc_valid <= 1'b1;
        desc_ctrl <= next_ctrl;
        desc_app <= app_i;
        in_packet <= !eof_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory read slave: one beat per four bytes, response chosen per request
  always_ff @(posedge link.clk_i) begin
    if (link.sys_rst_i) begin
      beats_left <= '0;
      resp <= RESP_OKAY;
      data_valid <= 1'b0;
      data <= '0;
    end else if (link.rd_req_valid && link.rd_req_ready) begin
      beats_left <= req_beats;
      resp <= resp_sel_i;
      data_valid <= 1'b1;
    end else if (beat_hit) begin
      beats_left <= beats_left - LEN_W'(1);
      data <= data + 32'h0000_0001;
      data_valid <= !last_beat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream sinks; registered ready lets the user stall the transmit path
  always_ff @(posedge link.clk_i) begin
    if (link.sys_rst_i) begin
      tx_ready <= 1'b0;
      tx_word_valid_o <= 1'b0;
      tx_word_o <= '0;
      tx_keep_o <= '0;
      tx_last_o <= 1'b0;
      cs_word_valid_o <= 1'b0;
      cs_word_o <= '0;
    end else begin
      tx_ready <= tx_ready_i;
      tx_word_valid_o <= link.tx_valid && tx_ready;
      tx_word_o <= link.tx_data;
      tx_keep_o <= link.tx_keep;
      tx_last_o <= link.tx_last;
      cs_word_valid_o <= link.cs_valid;
      cs_word_o <= link.cs_data;
    end
  end

endmodule : sg_sys_end

`default_nettype wire

// File: sg_tx_engine.sv
`default_nettype none

module sg_tx_engine
  import sg_pkg::*;
(
  sg_link_if.engine link,
  input wire logic start_i,
  input wire logic stop_i,
  output logic run_stop_bit_o,
  output logic halted_flag_o,
  output logic internal_error_flag_o,
  output logic slave_error_flag_o,
  output logic decode_error_flag_o,
  output logic sg_internal_error_o
);

  eng_state_t state;
  logic run_stop_bit;
  logic halted_flag;
  logic [31:0] ctrl;
  logic [APP_W-1:0] app;
  logic [2:0] app_idx;
  logic [LEN_W-1:0] remaining;
  logic [LEN_W-1:0] moved;
  logic int_err;
  logic slv_err;
  logic dec_err;
  logic sg_err;
  logic desc_ready;
  logic wb_valid;
  logic [31:0] wb_status;
  logic req_valid;
  logic cs_valid;
  logic [DATA_W-1:0] cs_data;
  logic cs_last;
  // Two-entry buffer: output stage and skid stage
  logic out_valid;
  logic [DATA_W-1:0] out_data;
  logic [KEEP_W-1:0] out_keep;
  logic out_last;
  logic skid_valid;
  logic [DATA_W-1:0] skid_data;
  logic [KEEP_W-1:0] skid_keep;
  logic skid_last;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the fetched descriptor and of incoming beats
  wire logic [LEN_W-1:0] ctrl_len = link.desc_ctrl[CTRL_LEN_MSB:0];
  wire logic [LEN_W-1:0] buf_len = ctrl[CTRL_LEN_MSB:0];
  wire logic is_sof = ctrl[CTRL_SOF_BIT];
  wire logic is_eof = ctrl[CTRL_EOF_BIT];
  wire logic fetch_hit = desc_ready && link.desc_valid;
  wire logic stale = link.desc_stat[ST_CMPLT_BIT];
  wire logic beat_in = (state == S_DATA) && !skid_valid && link.rd_data_valid;
  wire logic beat_slv = link.rd_resp == RESP_SLVERR;
  wire logic beat_dec = link.rd_resp == RESP_DECERR;
  wire logic beat_ok = link.rd_resp == RESP_OKAY;
  wire logic [2:0] nbytes = beat_bytes(remaining);
  wire logic push = beat_in && beat_ok && !slv_err && !dec_err;
  wire logic pop = out_valid && link.tx_ready;
  wire logic [KEEP_W-1:0] in_keep = keep_of(nbytes);
  // Packet boundary only on the final beat of the end-of-frame buffer
  wire logic in_last = link.rd_last && is_eof;
  wire logic any_err = int_err || slv_err || dec_err;
  wire logic cs_hit = cs_valid && link.cs_ready;
  wire logic wb_hit = wb_valid && link.wb_ready;
  wire logic [31:0] next_status = {!any_err, dec_err, slv_err, int_err, 5'h00, moved};

  ////////////////////////////////////////////////////////////////////////////
  // Link outputs from flip-flops, except read data ready, decoded from state and skid stage
  assign link.desc_ready = desc_ready;
  assign link.wb_valid = wb_valid;
  assign link.wb_status = wb_status;
  assign link.rd_req_valid = req_valid;
  assign link.rd_req_len = buf_len;
  // Ready in S_DATA is the inverse of the skid stage, so a stalled sink back-pressures the read
  assign link.rd_data_ready = (state == S_DATA) && !skid_valid;
  assign link.tx_valid = out_valid;
  assign link.tx_data = out_data;
  assign link.tx_keep = out_keep;
  assign link.tx_last = out_last;
  assign link.cs_valid = cs_valid;
  assign link.cs_data = cs_data;
  assign link.cs_last = cs_last;
  assign run_stop_bit_o = run_stop_bit;
  assign halted_flag_o = halted_flag;
  assign internal_error_flag_o = int_err;
  assign slave_error_flag_o = slv_err;
  assign decode_error_flag_o = dec_err;
  assign sg_internal_error_o = sg_err;

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor sequencer
  always_ff @(posedge link.clk_i) begin
    if (link.sys_rst_i) begin
      state <= S_HALT;
      run_stop_bit <= 1'b0;
      halted_flag <= 1'b1;
      ctrl <= 32'h0000_0000;
      app <= '0;
      app_idx <= 3'h0;
      remaining <= '0;
      moved <= '0;
      int_err <= 1'b0;
      slv_err <= 1'b0;
      dec_err <= 1'b0;
      sg_err <= 1'b0;
      desc_ready <= 1'b0;
      wb_valid <= 1'b0;
      wb_status <= STATUS_RST;
      req_valid <= 1'b0;
      cs_valid <= 1'b0;
      cs_data <= '0;
      cs_last <= 1'b0;
    end else begin
      // A stop request is honoured at the next descriptor boundary
      if (stop_i) begin
        run_stop_bit <= 1'b0;
      end
      unique case (state)
        S_HALT: begin
          if (start_i && !stop_i) begin
            run_stop_bit <= 1'b1;
            halted_flag <= 1'b0;
            int_err <= 1'b0;
            slv_err <= 1'b0;
            dec_err <= 1'b0;
            sg_err <= 1'b0;
            desc_ready <= 1'b1;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (fetch_hit) begin
            desc_ready <= 1'b0;
            ctrl <= link.desc_ctrl;
            app <= link.desc_app;
            remaining <= ctrl_len;
            moved <= '0;
            if (stale) begin
              // Stale descriptor: nothing was started, so stop at once
              sg_err <= 1'b1;
              run_stop_bit <= 1'b0;
              halted_flag <= 1'b1;
              state <= S_HALT;
            end else begin
              state <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          if (buf_len == '0) begin
            // Zero-length buffer: report it through the status word
            int_err <= 1'b1;
            run_stop_bit <= 1'b0;
            wb_valid <= 1'b1;
            wb_status <= {1'b0, 2'b00, 1'b1, 5'h00, {LEN_W{1'b0}}};
            state <= S_WB;
          end else if (is_sof && CS_STRM_EN) begin
            cs_valid <= 1'b1;
            cs_data <= app[DATA_W-1:0];
            cs_last <= 1'b0;
            app_idx <= 3'h0;
            state <= S_CTRL;
          end else begin
            req_valid <= 1'b1;
            state <= S_REQ;
          end
        end
        S_CTRL: begin
          if (cs_hit) begin
            if (cs_last) begin
              cs_valid <= 1'b0;
              req_valid <= 1'b1;
              state <= S_REQ;
            end else begin
              // Walk the user words in order, last flag on the fifth
              app_idx <= app_idx + 3'h1;
              cs_data <= app[(32'(app_idx) + 32'd1) * DATA_W +: DATA_W];
              cs_last <= (app_idx + 3'h1) == 3'(APP_N - 1);
            end
          end
        end
        S_REQ: begin
          if (link.rd_req_ready) begin
            req_valid <= 1'b0;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (beat_in) begin
            if (beat_slv) begin
              slv_err <= 1'b1;
              run_stop_bit <= 1'b0;
            end
            if (beat_dec) begin
              dec_err <= 1'b1;
              run_stop_bit <= 1'b0;
            end
            if (push) begin
              remaining <= remaining - LEN_W'(nbytes);
              moved <= moved + LEN_W'(nbytes);
            end
            // Keep draining the burst after an error so the slave is not left hanging
            if (link.rd_last) begin
              state <= S_DRAIN;
            end
          end
        end
        S_DRAIN: begin
          if (!out_valid && !skid_valid) begin
            wb_valid <= 1'b1;
            wb_status <= next_status;
            state <= S_WB;
          end
        end
        S_WB: begin
          if (wb_hit) begin
            wb_valid <= 1'b0;
            if (any_err || !run_stop_bit) begin
              run_stop_bit <= 1'b0;
              halted_flag <= 1'b1;
              state <= S_HALT;
            end else begin
              desc_ready <= 1'b1;
              state <= S_FETCH;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry transmit buffer; skid stage catches the beat in flight on a stall
  always_ff @(posedge link.clk_i) begin
    if (link.sys_rst_i) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_keep <= '0;
      out_last <= 1'b0;
      skid_valid <= 1'b0;
      skid_data <= '0;
      skid_keep <= '0;
      skid_last <= 1'b0;
    end else if (!out_valid || pop) begin
      if (skid_valid) begin
        out_data <= skid_data;
        out_keep <= skid_keep;
        out_last <= skid_last;
        skid_valid <= 1'b0;
      end else begin
        out_valid <= push;
        out_data <= link.rd_data;
        out_keep <= in_keep;
        out_last <= in_last;
      end
    end else if (push) begin
      skid_valid <= 1'b1;
      skid_data <= link.rd_data;
      skid_keep <= in_keep;
      skid_last <= in_last;
    end
  end

endmodule : sg_tx_engine

`default_nettype wire

// File: tb.sv
`default_nettype none

module tb
  import sg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [APP_W-1:0] APP_V = {32'h0000_00A4, 32'h0000_00A3, 32'h0000_00A2, 32'h0000_00A1, 32'h0000_00A0};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic start_b = 1'b0;
  logic stop_i = 1'b0;
  logic push_i = 1'b0;
  logic eof_i = 1'b0;
  logic tx_ready_i = 1'b1;
  logic [LEN_W-1:0] len_i = '0;
  logic [1:0] resp_sel_i = 2'h0;
  logic run_stop, halted, int_err, slv_err, dec_err, halted_b, sg_err_b;
  logic busy, st_valid, txv, tx_last, csv;
  logic [31:0] st, csw, seen, tx_word, last_word;
  logic [KEEP_W-1:0] tx_keep, last_keep;
  logic [31:0] cs_q[$];
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int tx_bytes = 0;
  int tx_lasts = 0;
  int wb_b = 0;
  int n;

  always #2 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////
  sg_link_if link (.clk_i(clk_i), .sys_rst_i(sys_rst_i));
  sg_link_if link_b (.clk_i(clk_i), .sys_rst_i(sys_rst_i));
  sg_tx_engine i_sg_tx_engine (.link(link.engine), .start_i(start_i), .stop_i(stop_i), .run_stop_bit_o(run_stop),
    .halted_flag_o(halted), .internal_error_flag_o(int_err), .slave_error_flag_o(slv_err),
    .decode_error_flag_o(dec_err), .sg_internal_error_o());
  sg_sys_end i_sg_sys_end (.link(link.system), .push_i(push_i), .len_i(len_i), .eof_i(eof_i), .app_i(APP_V),
    .resp_sel_i(resp_sel_i), .tx_ready_i(tx_ready_i), .busy_o(busy), .status_valid_o(st_valid), .status_o(st),
    .tx_word_valid_o(txv), .tx_word_o(tx_word), .tx_keep_o(tx_keep), .tx_last_o(tx_last), .cs_word_valid_o(csv),
    .cs_word_o(csw));
  // Second engine faces the bench alone, so it can be handed a stale descriptor
  sg_tx_engine i_sg_tx_engine_b (.link(link_b.engine), .start_i(start_b), .stop_i(1'b0), .run_stop_bit_o(),
    .halted_flag_o(halted_b), .internal_error_flag_o(), .slave_error_flag_o(), .decode_error_flag_o(),
    .sg_internal_error_o(sg_err_b));
  sg_link_checker i_sg_link_checker (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .desc_valid(link.desc_valid),
    .desc_ready(link.desc_ready), .desc_ctrl(link.desc_ctrl), .wb_valid(link.wb_valid), .wb_status(link.wb_status),
    .rd_req_valid(link.rd_req_valid), .rd_req_len(link.rd_req_len), .rd_data_valid(link.rd_data_valid),
    .rd_data_ready(link.rd_data_ready), .rd_resp(link.rd_resp), .tx_valid(link.tx_valid), .tx_last(link.tx_last),
    .cs_valid(link.cs_valid), .cs_ready(link.cs_ready), .cs_last(link.cs_last));

  // Pulses sampled at the falling edge, where registered outputs have settled
  always @(negedge clk_i) begin
    cycles++;
    if (txv === 1'b1) begin
      tx_bytes += $countones(tx_keep);
      last_keep = tx_keep;
      last_word = tx_word;
      tx_lasts += (tx_last === 1'b1) ? 1 : 0;
    end
    if (csv === 1'b1) begin
      cs_q.push_back(csw);
    end
    wb_b += (link_b.wb_valid === 1'b1) ? 1 : 0;
    if (cycles == 4000) begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Pushes are refused while busy, so wait it out first
  task automatic push(input logic [LEN_W-1:0] len, input logic eof, input logic [1:0] resp);
    for (int k = 0; k < 500 && busy !== 1'b0; k++) begin
      @(negedge clk_i);
    end
    len_i = len;
    eof_i = eof;
    resp_sel_i = resp;
    push_i = 1'b1;
    @(negedge clk_i);
    push_i = 1'b0;
  endtask : push

  task automatic wait_status();
    for (int k = 0; k < 500 && st_valid !== 1'b1; k++) begin
      @(negedge clk_i);
    end
    seen = st;
    check("status pulse", st_valid, 32'h1);
    @(negedge clk_i);
  endtask : wait_status

  task automatic restart();
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
  endtask : restart

  initial begin
    link_b.desc_valid = 1'b0;
    link_b.desc_ctrl = 32'h0C00_0004;
    link_b.desc_stat = 32'h8000_0000;
    link_b.desc_app = '0;
    link_b.wb_ready = 1'b1;
    link_b.rd_req_ready = 1'b1;
    link_b.rd_data_valid = 1'b0;
    link_b.rd_data = '0;
    link_b.rd_resp = 2'h0;
    link_b.rd_last = 1'b0;
    link_b.tx_ready = 1'b1;
    link_b.cs_ready = 1'b1;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    check("halted at reset", halted, 32'h1);
    restart();
    check("running", run_stop, 32'h1);
    // Whole packet in one descriptor, two-byte tail
    push(23'h00000A, 1'b1, RESP_OKAY);
    wait_status();
    check("status", seen, 32'h8000_000A);
    check("tail keep", 32'(last_keep), 32'h3);
    // Memory pattern counts up from zero, so the third beat carries 2
    check("tail word", last_word, 32'h2);
    for (int k = 0; k < APP_N; k++) begin
      check("user word", cs_q[k], APP_V[32*k +: 32]);
    end
    // Two-descriptor packet with the receiver stalled past the buffer depth
    tx_ready_i = 1'b0;
    push(23'h000010, 1'b0, RESP_OKAY);
    repeat (20) @(negedge clk_i);
    check("stall refuses data", link.rd_data_ready, 32'h0);
    tx_ready_i = 1'b1;
    wait_status();
    check("status", seen, 32'h8000_0010);
    push(23'h000004, 1'b1, RESP_OKAY);
    wait_status();
    check("status", seen, 32'h8000_0004);
    check("tx bytes", 32'(tx_bytes), 32'h1E);
    check("frame ends", 32'(tx_lasts), 32'h2);
    check("user words", 32'(cs_q.size()), 32'hA);
    // Zero length is an internal error and stops the engine
    push(23'h000000, 1'b1, RESP_OKAY);
    wait_status();
    check("status", seen, 32'h1000_0000);
    repeat (4) @(negedge clk_i);
    check("flags", 32'({int_err, run_stop, halted}), 32'h5);
    // Slave then decode error responses on the buffer read
    for (int k = 0; k < 2; k++) begin
      restart();
      push(23'h000010, 1'b1, (k == 1) ? RESP_DECERR : RESP_SLVERR);
      wait_status();
      check("error bits", 32'(seen[31:28]), (k == 1) ? 32'h4 : 32'h2);
      repeat (4) @(negedge clk_i);
      check("flags", 32'({int_err, dec_err, slv_err, run_stop, halted}), (k == 1) ? 32'h9 : 32'h5);
    end
    // A stop request lets the descriptor in hand finish, then halts
    restart();
    stop_i = 1'b1;
    push(23'h000004, 1'b1, RESP_OKAY);
    stop_i = 1'b0;
    wait_status();
    check("status after stop", seen, 32'h8000_0004);
    check("stopped", 32'({run_stop, halted}), 32'h1);
    // A descriptor already marked complete must be refused
    link_b.desc_valid = 1'b1;
    start_b = 1'b1;
    @(negedge clk_i);
    start_b = 1'b0;
    for (n = 0; n < 100 && link_b.desc_ready !== 1'b1; n++) begin
      @(negedge clk_i);
    end
    check("engine b running", halted_b, 32'h0);
    @(negedge clk_i);
    link_b.desc_valid = 1'b0;
    repeat (8) @(negedge clk_i);
    check("stale flags", 32'({sg_err_b, halted_b}), 32'h3);
    check("stale write-backs", 32'(wb_b), 32'h0);
    finish_test();
  end

endmodule : tb

`default_nettype wire
